// file: shared/rpm_pkg.sv
// package: constants and carrier types for the rx-port misc control register bank
// Notes on behaviour
// - raw mode emits frame start only after frame valid held the programmed minimum.
// - minimum counted in link clock periods; field resets to 0x80.
// - eight pull-down disable bits, bit n for pin n, reset zero.
// - pull-down on automatically whenever pin is not an output, unless disabled.
// - disable bit set keeps pull-down off even for inputs; clear restores auto.
// - debug register exists per receive port, reached via port-select register.
// - read-only bit 5 shows remote serializer in self-test.
// - bit 1 set corrupts every back-channel frame until cleared.
// - writing 1 to bit 0 injects one error, then self-clears; 0 ignored.
`default_nettype none
package rpm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_FVAL_MIN = 8'hbc;
  localparam logic [7:0] ADDR_PD_DIS = 8'hbe;
  localparam logic [7:0] ADDR_DEBUG = 8'hd0;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;

  localparam logic [7:0] RST_FVAL_MIN = 8'h80;
  localparam logic [7:0] RST_PD_DIS = 8'h00;
  localparam logic [7:0] RST_DEBUG = 8'h00;
  localparam logic [7:0] RST_PORT_SEL = 8'h00;

  // debug field positions
  localparam int BIT_ONCE = 0;
  localparam int BIT_CONT = 1;
  localparam int BIT_SELFTEST = 5;

  localparam int NUM_PORTS = 4;
  localparam int NUM_PINS = 8;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpm_req_s;

  typedef struct packed {
    logic cont;
    logic once;
  } rpm_dbg_s;

  typedef enum logic [1:0] {
    GATE_IDLE,
    GATE_COUNT,
    GATE_DONE
  } rpm_gate_e;

  typedef struct packed {
    logic [7:0] fval_min;
    logic [7:0] pd_dis;
    logic [7:0] port_sel;
    rpm_dbg_s [NUM_PORTS-1:0] dbg;
    rpm_gate_e gate_state;
    logic [7:0] gate_count;
    logic frame_start;
    logic [7:0] rdata;
    logic rvalid;
  } rpm_state_s;

endpackage : rpm_pkg
`default_nettype wire

// file: core/rpm_regs.sv
// module: rx-port misc control registers, frame-start gating and back-channel error injection
`timescale 1ns/1ps
`default_nettype none
module rpm_regs (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port
  input wire rpm_pkg::rpm_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // raw-mode receiver (selected port)
  input wire logic i_raw_mode,
  input wire logic frame_valid_in,
  output logic o_frame_start,
  // general-purpose pins
  input wire logic [7:0] i_pin_is_output,
  output logic [7:0] o_pin_pulldown_en,
  // back channel, one lane per receive port
  input wire logic [3:0] i_remote_selftest_active,
  input wire logic [3:0] i_backchan_frame,
  output logic [3:0] o_backchan_corrupt
);

  // ****************************************
  // state
  // ****************************************
  rpm_pkg::rpm_state_s state;
  rpm_pkg::rpm_state_s next_state;

  // ****************************************
  // decode helpers
  // ****************************************

  // a write strobe aimed at one register offset
  function automatic logic write_hit(
    input rpm_pkg::rpm_req_s req,
    input logic [7:0] offset
  );
    return req.wr && (req.addr == offset);
  endfunction : write_hit

  // a read strobe aimed at one register offset
  function automatic logic read_hit(
    input rpm_pkg::rpm_req_s req,
    input logic [7:0] offset
  );
    return req.rd && (req.addr == offset);
  endfunction : read_hit

  // only the low bits pick a port; the upper bits read back as zero
  function automatic logic [7:0] port_sel_value(input logic [7:0] wdata);
    logic [7:0] v;
    v = 8'h00;
    v[1:0] = wdata[1:0];
    return v;
  endfunction : port_sel_value

  // reserved debug bits always read as zero
  function automatic logic [7:0] dbg_read(
    input rpm_pkg::rpm_dbg_s d,
    input logic st
  );
    logic [7:0] v;
    v = 8'h00;
    v[rpm_pkg::BIT_SELFTEST] = st;
    v[rpm_pkg::BIT_CONT] = d.cont;
    v[rpm_pkg::BIT_ONCE] = d.once;
    return v;
  endfunction : dbg_read

  // pull-down is automatic for a pin that is not driving, unless disabled
  function automatic logic pulldown_auto(
    input logic is_output,
    input logic disable_bit
  );
    return !is_output && !disable_bit;
  endfunction : pulldown_auto

  // a port corrupts the frame it is sending while either injector is armed
  function automatic logic corrupt_now(
    input logic frame,
    input rpm_pkg::rpm_dbg_s d
  );
    return frame && (d.cont || d.once);
  endfunction : corrupt_now

  // ****************************************
  // request decode
  // ****************************************
  logic [1:0] sel;
  logic dbg_wr;
  logic once_req;
  logic gate_open;
  logic count_reached;

  assign sel = state.port_sel[1:0];
  assign dbg_wr = write_hit(i_req, rpm_pkg::ADDR_DEBUG);
  assign once_req = dbg_wr & i_req.wdata[rpm_pkg::BIT_ONCE];
  assign gate_open = frame_valid_in & i_raw_mode;
  assign count_reached = (state.gate_count >= state.fval_min);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.frame_start = 1'b0;
    next_state.rvalid = i_req.rd;

    // ****************************************
    // register writes
    // ****************************************
    if (write_hit(i_req, rpm_pkg::ADDR_FVAL_MIN)) begin
      next_state.fval_min = i_req.wdata;
    end
    if (write_hit(i_req, rpm_pkg::ADDR_PD_DIS)) begin
      next_state.pd_dis = i_req.wdata;
    end
    if (write_hit(i_req, rpm_pkg::ADDR_PORT_SEL)) begin
      next_state.port_sel = port_sel_value(i_req.wdata);
    end
    if (dbg_wr) begin
      // only the selected port's copy is touched
      next_state.dbg[sel].cont = i_req.wdata[rpm_pkg::BIT_CONT];
    end

    // ****************************************
    // one-shot injection per port
    // ****************************************
    for (int p = 0; p < rpm_pkg::NUM_PORTS; p++) begin
      // a pending request is consumed by the next frame, then self-clears
      if (state.dbg[p].once && i_backchan_frame[p]) begin
        next_state.dbg[p].once = 1'b0;
      end
      // a new write of 1 in the same cycle wins over the clear; 0 is ignored
      if (once_req && (sel == 2'(p))) begin
        next_state.dbg[p].once = 1'b1;
      end
    end

    // ****************************************
    // frame-valid minimum time
    // ****************************************
    unique case (state.gate_state)
      rpm_pkg::GATE_IDLE: begin
        next_state.gate_count = 8'h00;
        if (gate_open) begin
          next_state.gate_state = rpm_pkg::GATE_COUNT;
          next_state.gate_count = 8'h01;
        end
      end
      rpm_pkg::GATE_COUNT: begin
        if (!frame_valid_in) begin
          // a short pulse leaves no trace: the next one counts from scratch
          next_state.gate_state = rpm_pkg::GATE_IDLE;
          next_state.gate_count = 8'h00;
        end else if (count_reached) begin
          next_state.frame_start = 1'b1;
          next_state.gate_state = rpm_pkg::GATE_DONE;
        end else begin
          // counter never wraps: it stops at the programmed minimum
          next_state.gate_count = state.gate_count + 8'h01;
        end
      end
      rpm_pkg::GATE_DONE: begin
        // one start per assertion; wait for the frame to end
        if (!frame_valid_in) begin
          next_state.gate_state = rpm_pkg::GATE_IDLE;
        end
      end
      default: begin
        next_state.gate_state = rpm_pkg::GATE_IDLE;
        next_state.gate_count = 8'h00;
      end
    endcase

    // ****************************************
    // read data
    // ****************************************
    next_state.rdata = 8'h00;
    if (read_hit(i_req, rpm_pkg::ADDR_FVAL_MIN)) begin
      next_state.rdata = state.fval_min;
    end
    if (read_hit(i_req, rpm_pkg::ADDR_PD_DIS)) begin
      next_state.rdata = state.pd_dis;
    end
    if (read_hit(i_req, rpm_pkg::ADDR_PORT_SEL)) begin
      next_state.rdata = state.port_sel;
    end
    if (read_hit(i_req, rpm_pkg::ADDR_DEBUG)) begin
      // self-test flag is live: no latching, so it tracks the remote side
      next_state.rdata = dbg_read(state.dbg[sel], i_remote_selftest_active[sel]);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state.fval_min <= rpm_pkg::RST_FVAL_MIN;
      state.pd_dis <= rpm_pkg::RST_PD_DIS;
      state.port_sel <= rpm_pkg::RST_PORT_SEL;
      state.dbg <= '0;
      state.gate_state <= rpm_pkg::GATE_IDLE;
      state.gate_count <= 8'h00;
      state.frame_start <= 1'b0;
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = state.rdata;
  assign o_rvalid = state.rvalid;
  assign o_frame_start = state.frame_start;

  // pull-down only ever applies to pins that are not driving
  for (genvar n = 0; n < rpm_pkg::NUM_PINS; n++) begin : g_pulldown
    assign o_pin_pulldown_en[n] = pulldown_auto(i_pin_is_output[n], state.pd_dis[n]);
  end

  // corruption follows the frame pulse combinationally, so it lands in that very frame
  for (genvar p = 0; p < rpm_pkg::NUM_PORTS; p++) begin : g_corrupt
    assign o_backchan_corrupt[p] = corrupt_now(i_backchan_frame[p], state.dbg[p]);
  end

endmodule : rpm_regs
`default_nettype wire

// file: testbench/rpm_regs_chk.sv
// checker: port assertions for the rx-port misc register bank
`timescale 1ns/1ps
`default_nettype none
module rpm_regs_chk (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire rpm_pkg::rpm_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_raw_mode,
  input wire logic frame_valid_in,
  input wire logic o_frame_start,
  input wire logic [7:0] i_pin_is_output,
  input wire logic [7:0] o_pin_pulldown_en,
  input wire logic [3:0] i_remote_selftest_active,
  input wire logic [3:0] i_backchan_frame,
  input wire logic [3:0] o_backchan_corrupt
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  pd_output_a: assert property ((o_pin_pulldown_en & i_pin_is_output) == 8'h00)
    else $error("pulldown on output pin");
  read_answer_a: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  start_gate_a: assert property (o_frame_start |-> $past(i_raw_mode) && $past(frame_valid_in))
    else $error("start outside raw frame");
  start_once_a: assert property (o_frame_start |=> !o_frame_start)
    else $error("start too long");
  start_drop_a: assert property (!frame_valid_in |=> !o_frame_start)
    else $error("start after drop");
  corrupt_frame_a: assert property ((o_backchan_corrupt & ~i_backchan_frame) == 4'h0)
    else $error("corrupt without frame");
  dbg_resv_a: assert property (o_rvalid && $past(i_req.addr) == 8'hd0 |-> (o_rdata & 8'hdc) == 8'h00)
    else $error("debug reserved bit set");
  unmapped_a: assert property (o_rvalid && !($past(i_req.addr) inside {8'hbc, 8'hbe, 8'hd0, 8'h4c})
    |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (o_frame_start);
  cover property (|o_backchan_corrupt);
  cover property (o_rvalid && o_rdata[5]);
endmodule : rpm_regs_chk
bind rpm_regs rpm_regs_chk u_rpm_regs_chk (.*);
`default_nettype wire

// file: testbench/rpm_regs_tb.sv
// testbench: register, pin and back-channel checks for the rx-port misc bank
`timescale 1ns/1ps
`default_nettype none
module rpm_regs_tb;
  logic i_clock = 0, i_arst_n = 0, i_raw_mode = 0, frame_valid_in = 0, o_frame_start, o_rvalid;
  rpm_pkg::rpm_req_s i_req = '0;
  logic [7:0] i_pin_is_output = 8'h0f, o_rdata, o_pin_pulldown_en;
  logic [3:0] i_remote_selftest_active = 4'h4, i_backchan_frame = 4'h0, o_backchan_corrupt;
  int n_mismatch = 0, num_checks = 0, k, at;
  always #2.5 i_clock = ~i_clock;
  rpm_regs u_rpm_regs (.*);
  task automatic chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cyc;
    @(posedge i_clock) #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    i_req = '{1'b1, 1'b0, a, d};
    cyc();
    i_req = '0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, e);
    i_req = '{1'b0, 1'b1, a, 8'h00};
    cyc();
    i_req = '0;
    chk(o_rdata, e);
  endtask : rdc
  // frame pulse lasts one cycle; corrupt is combinational with it
  task automatic bc(input logic [3:0] f, e);
    i_backchan_frame = f;
    #1 chk({4'h0, o_backchan_corrupt}, {4'h0, e});
    cyc();
    i_backchan_frame = 4'h0;
  endtask : bc
  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    #1 i_arst_n = 1;
    cyc();
    rdc(8'hbc, 8'h80);
    rdc(8'hbe, 8'h00);
    rdc(8'h33, 8'h00);
    chk(o_pin_pulldown_en, 8'hf0);
    wr(8'hbe, 8'h30);
    chk(o_pin_pulldown_en, 8'hc0);
    wr(8'hbe, 8'h00);
    chk(o_pin_pulldown_en, 8'hf0);
    wr(8'h4c, 8'h02);
    wr(8'hd0, 8'h02);
    rdc(8'hd0, 8'h22);
    bc(4'h4, 4'h4);
    wr(8'h4c, 8'h01);
    rdc(8'hd0, 8'h00);
    wr(8'hd0, 8'h01);
    rdc(8'hd0, 8'h01);
    bc(4'h6, 4'h6);
    bc(4'h6, 4'h4);
    rdc(8'hd0, 8'h00);
    wr(8'hbc, 8'h03);
    i_raw_mode = 1;
    frame_valid_in = 1;
    repeat (2) cyc();
    frame_valid_in = 0;
    k = 0;
    at = 0;
    // short pulse above must add nothing; the long one exactly one start
    for (int i = 0; i < 16; i++) begin
      frame_valid_in = (i > 2);
      cyc();
      k += int'(o_frame_start);
      if (o_frame_start) at = i;
    end
    chk(8'(k), 8'h01);
    chk(8'(at), 8'h06);
    frame_valid_in = 0;
    cyc();
    i_raw_mode = 0;
    frame_valid_in = 1;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      cyc();
      k += int'(o_frame_start);
    end
    chk(8'(k), 8'h00);
    give_verdict();
  end
endmodule : rpm_regs_tb
`default_nettype wire
